// File: pipm_defines.svh
// pipm_defines.svh: offsets, field positions and reset values of the pin
// interrupt and pattern match block.
// assumes it is included by the package, the block and the test, once each.
`ifndef PIPM_DEFINES_SVH
`define PIPM_DEFINES_SVH
`define PIPM_NCH          8
`define PIPM_ADDR_W       6
// register offsets, byte addresses
`define PIPM_REG_MODE     6'h00
`define PIPM_REG_ENRISE   6'h04
`define PIPM_REG_ENFALL   6'h08
`define PIPM_REG_RISEFLG  6'h0c
`define PIPM_REG_FALLFLG  6'h10
`define PIPM_REG_STATUS   6'h14
`define PIPM_REG_PMCTRL   6'h18
`define PIPM_REG_PMSRC    6'h1c
`define PIPM_REG_PMCFG    6'h20
`define PIPM_REG_PMTERM   6'h24
`define PIPM_REG_PINS     6'h28
// pattern control fields
`define PIPM_PMCTRL_SEL   0
`define PIPM_PMCTRL_EVEN  1
// per-slice condition encodings, 3 bits each
`define PIPM_CND_HIGH     3'h0
`define PIPM_CND_LOW      3'h1
`define PIPM_CND_RISE     3'h2
`define PIPM_CND_FALL     3'h3
`define PIPM_CND_EDGE     3'h4
`define PIPM_CND_ONE      3'h5
`define PIPM_CND_ZERO     3'h6
`define PIPM_RST_WORD     32'h0000_0000
`endif

// File: pipm_pkg.sv
// pipm_pkg.sv: types of the pin interrupt and pattern match block.
// assumes pipm_defines.svh sits beside it.
`include "pipm_defines.svh"
package pipm_pkg;
  typedef logic [`PIPM_NCH-1:0] pipm_vec_type;

  typedef struct packed {
    logic [`PIPM_ADDR_W-1:0] addr;
    logic [31:0]             wdata;
    logic                    wr;
    logic                    rd;
  } pipm_bus_type;

  typedef struct packed {
    pipm_vec_type pinSync1;
    pipm_vec_type pinSync2;
    pipm_vec_type pinPrev;
    pipm_vec_type levelMode;
    pipm_vec_type enRise;
    pipm_vec_type enFall;
    pipm_vec_type riseFlag;
    pipm_vec_type fallFlag;
    pipm_vec_type irq;
    logic         wake;
    logic         patSel;
    logic         evEnable;
    logic [23:0]  pmSrc;
    logic [23:0]  pmCfg;
    pipm_vec_type termEnd;
    pipm_vec_type termHit;
    logic         evPulse;
    logic [31:0]  rdata;
  } pipm_state_type;
endpackage : pipm_pkg

// File: pipm_engine.sv
// pipm_engine.sv: eight pin interrupt channels and a pattern match engine.
// assumes pins are chosen outside (system configuration block) and are
// synchronous to clock; software drives the plain register port.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "pipm_defines.svh"
module pipm_engine
  import pipm_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic [`PIPM_NCH-1:0]    pinIn,
  input  wire logic [`PIPM_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]             regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [31:0]             regRdata,
  output logic      [`PIPM_NCH-1:0]    irqOut,
  output logic                         wakeOut,
  output logic                         eventOut
);
  pipm_state_type s_q;
  pipm_state_type s_d;
  pipm_bus_type   bus;

  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // condition of one slice against the synchronised pins
  function automatic logic slice_hit(input logic [2:0] cnd,
                                     input logic cur, input logic prv,
                                     input logic edg);
    unique case (cnd)
      `PIPM_CND_HIGH: slice_hit = cur;
      `PIPM_CND_LOW:  slice_hit = !cur;
      `PIPM_CND_RISE: slice_hit = edg & cur & !prv;
      `PIPM_CND_FALL: slice_hit = edg & !cur & prv;
      `PIPM_CND_EDGE: slice_hit = edg & (cur ^ prv);
      `PIPM_CND_ONE:  slice_hit = 1'b1;
      default:        slice_hit = 1'b0;
    endcase
  endfunction : slice_hit

  logic [`PIPM_NCH-1:0] rise;
  logic [`PIPM_NCH-1:0] fall;
  logic [`PIPM_NCH-1:0] term;
  logic                 acc;
  logic [2:0]           src;

  always_comb begin
    rise = s_q.pinSync2 & ~s_q.pinPrev;
    fall = ~s_q.pinSync2 & s_q.pinPrev;
    // product terms: slices chained until a slice marked as term end
    acc  = 1'b1;
    term = '0;
    for (int i = 0; i < `PIPM_NCH; i++) begin
      src = s_q.pmSrc[3*i +: 3];
      acc = acc & slice_hit(s_q.pmCfg[3*i +: 3], s_q.pinSync2[src],
                            s_q.pinPrev[src], 1'b1);
      if (s_q.termEnd[i]) begin
        term[i] = acc;
        acc     = 1'b1;
      end
    end

    s_d          = s_q;
    s_d.pinSync1 = pinIn;
    s_d.pinSync2 = s_q.pinSync1;
    s_d.pinPrev  = s_q.pinSync2;
    s_d.evPulse  = 1'b0;

    // flags: hardware set wins over a software clear in the same cycle
    if (bus.wr && bus.addr == `PIPM_REG_RISEFLG)
      s_d.riseFlag = s_q.riseFlag & ~bus.wdata[`PIPM_NCH-1:0];
    if (bus.wr && bus.addr == `PIPM_REG_FALLFLG)
      s_d.fallFlag = s_q.fallFlag & ~bus.wdata[`PIPM_NCH-1:0];
    if (bus.wr && bus.addr == `PIPM_REG_STATUS) begin
      s_d.riseFlag = s_d.riseFlag & ~(bus.wdata[`PIPM_NCH-1:0] & ~s_q.levelMode);
      s_d.fallFlag = s_d.fallFlag & ~(bus.wdata[`PIPM_NCH-1:0] & ~s_q.levelMode);
    end
    s_d.riseFlag = s_d.riseFlag | (rise & ~s_q.levelMode);
    s_d.fallFlag = s_d.fallFlag | (fall & ~s_q.levelMode);

    if (bus.wr) begin
      unique case (bus.addr)
        `PIPM_REG_MODE:   s_d.levelMode = bus.wdata[`PIPM_NCH-1:0];
        `PIPM_REG_ENRISE: s_d.enRise    = bus.wdata[`PIPM_NCH-1:0];
        `PIPM_REG_ENFALL: s_d.enFall    = bus.wdata[`PIPM_NCH-1:0];
        `PIPM_REG_PMCTRL: begin
          s_d.patSel   = bus.wdata[`PIPM_PMCTRL_SEL];
          s_d.evEnable = bus.wdata[`PIPM_PMCTRL_EVEN];
        end
        `PIPM_REG_PMSRC:  s_d.pmSrc   = bus.wdata[23:0];
        `PIPM_REG_PMCFG:  s_d.pmCfg   = bus.wdata[23:0];
        `PIPM_REG_PMTERM: s_d.termEnd = bus.wdata[`PIPM_NCH-1:0];
        default: ;
      endcase
    end

    // level mode: enRise enables, enFall chooses high (0) or low (1)
    s_d.termHit = s_q.patSel ? term : '0;
    for (int i = 0; i < `PIPM_NCH; i++) begin
      if (s_q.patSel)
        s_d.irq[i] = term[i];
      else if (s_q.levelMode[i])
        s_d.irq[i] = s_q.enRise[i] &
                     (s_q.pinSync2[i] ^ s_q.enFall[i]);
      else
        s_d.irq[i] = (s_q.riseFlag[i] & s_q.enRise[i]) |
                     (s_q.fallFlag[i] & s_q.enFall[i]);
    end
    // only plain channel requests may wake the part
    s_d.wake    = !s_q.patSel && (|s_d.irq);
    // one pulse per new match, so a held pattern is not a stream of events
    s_d.evPulse = s_q.patSel && s_q.evEnable
                  && (|(term & ~s_q.termHit));

    s_d.rdata = `PIPM_RST_WORD;
    if (bus.rd) begin
      unique case (bus.addr)
        `PIPM_REG_MODE:    s_d.rdata[`PIPM_NCH-1:0] = s_q.levelMode;
        `PIPM_REG_ENRISE:  s_d.rdata[`PIPM_NCH-1:0] = s_q.enRise;
        `PIPM_REG_ENFALL:  s_d.rdata[`PIPM_NCH-1:0] = s_q.enFall;
        `PIPM_REG_RISEFLG: s_d.rdata[`PIPM_NCH-1:0] = s_q.riseFlag;
        `PIPM_REG_FALLFLG: s_d.rdata[`PIPM_NCH-1:0] = s_q.fallFlag;
        `PIPM_REG_STATUS:  s_d.rdata[`PIPM_NCH-1:0] = s_q.irq;
        `PIPM_REG_PMCTRL:  s_d.rdata[1:0] = {s_q.evEnable, s_q.patSel};
        `PIPM_REG_PMSRC:   s_d.rdata[23:0] = s_q.pmSrc;
        `PIPM_REG_PMCFG:   s_d.rdata[23:0] = s_q.pmCfg;
        `PIPM_REG_PMTERM:  s_d.rdata[`PIPM_NCH-1:0] = s_q.termEnd;
        `PIPM_REG_PINS:    s_d.rdata[`PIPM_NCH-1:0] = s_q.pinSync2;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata = s_q.rdata;
  assign irqOut   = s_q.irq;
  assign wakeOut  = s_q.wake;
  assign eventOut = s_q.evPulse;

  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // an edge request needs the channel armed for two cycles: one to set
  // the flag, one more to register the request
  sequence riseSeen(int k);
    !s_q.pinSync2[k] ##1 s_q.pinSync2[k];
  endsequence

  sequence fallSeen(int k);
    s_q.pinSync2[k] ##1 !s_q.pinSync2[k];
  endsequence

  sequence riseOn(int k);
    !s_q.patSel && !s_q.levelMode[k] && s_q.enRise[k];
  endsequence

  sequence fallOn(int k);
    !s_q.patSel && !s_q.levelMode[k] && s_q.enFall[k];
  endsequence

  sequence riseArmed(int k);
    riseSeen(k) ##0 riseOn(k) ##1 riseOn(k);
  endsequence

  sequence fallArmed(int k);
    fallSeen(k) ##0 fallOn(k) ##1 fallOn(k);
  endsequence

  rise_flag_a: assert property (
    riseArmed(0) |=> irqOut[0]) else $error("rise edge missed");

  fall_flag_a: assert property (
    fallArmed(0) |=> irqOut[0]) else $error("fall edge missed");

  sync_delay_a: assert property (
    ##2 s_q.pinSync2 == $past(pinIn, 2)) else $error("sync depth wrong");
  level_hi_a: assert property (
    (!s_q.patSel && s_q.levelMode[1] && s_q.enRise[1] && !s_q.enFall[1]
     && s_q.pinSync2[1] && $stable(s_q.patSel))
      |=> irqOut[1]) else $error("level high missed");
  level_lo_a: assert property (
    (!s_q.patSel && s_q.levelMode[2] && !s_q.enRise[2]) |=> !irqOut[2])
    else $error("disabled level asserted");
  no_wake_a: assert property (
    s_q.patSel && $stable(s_q.patSel) |-> !wakeOut)
    else $error("pattern woke part");
  wake_irq_a: assert property (
    wakeOut |-> (|irqOut)) else $error("wake without request");
  event_gate_a: assert property (
    eventOut |-> $past(s_q.evEnable)) else $error("event while disabled");
  read_one_a: assert property (
    (regRd && regAddr == `PIPM_REG_MODE) |=> regRdata[7:0] == $past(s_q.levelMode))
    else $error("read data late");
  term_irq_a: assert property (
    s_q.patSel && s_q.termEnd[0] && s_q.pmCfg[2:0] == `PIPM_CND_ONE
      |=> $past(s_q.patSel) |-> irqOut[0]) else $error("term request missing");
  chan_sep_a: assert property (
    (!s_q.patSel && ~|(s_q.enRise | s_q.enFall)) |=> !$past(s_q.patSel) |-> irqOut == '0)
    else $error("request without enable");

  // edge flags
  rise_set_a: assert property (
    rise[3] && !s_q.levelMode[3] |=> s_q.riseFlag[3])
    else $error("rise flag not set");

  fall_set_a: assert property (
    fall[3] && !s_q.levelMode[3] |=> s_q.fallFlag[3])
    else $error("fall flag not set");

  level_noflag_a: assert property (
    s_q.levelMode[4] && !s_q.riseFlag[4] && !s_q.fallFlag[4]
      |=> !s_q.riseFlag[4] && !s_q.fallFlag[4])
    else $error("level channel set a flag");

  rise_clear_a: assert property (
    regWr && regAddr == `PIPM_REG_RISEFLG && regWdata[5] && !rise[5]
      |=> !s_q.riseFlag[5]) else $error("rise flag not cleared");

  fall_clear_a: assert property (
    regWr && regAddr == `PIPM_REG_FALLFLG && regWdata[5] && !fall[5]
      |=> !s_q.fallFlag[5]) else $error("fall flag not cleared");

  status_clear_a: assert property (
    regWr && regAddr == `PIPM_REG_STATUS && regWdata[6]
      && !s_q.levelMode[6] && !rise[6]
      |=> !s_q.riseFlag[6]) else $error("status write kept flag");

  // channel requests
  edge_irq_a: assert property (
    !s_q.patSel && !s_q.levelMode[2]
      |=> irqOut[2] == $past((s_q.riseFlag[2] & s_q.enRise[2])
                             | (s_q.fallFlag[2] & s_q.enFall[2])))
    else $error("edge request wrong");

  level_irq_a: assert property (
    !s_q.patSel && s_q.levelMode[5]
      |=> irqOut[5] == $past(s_q.enRise[5]
                             & (s_q.pinSync2[5] ^ s_q.enFall[5])))
    else $error("level request wrong");

  wake_pin_a: assert property (
    !s_q.patSel |=> wakeOut == (|irqOut))
    else $error("wake not from requests");

  // pattern engine
  pat_irq_a: assert property (
    s_q.patSel |=> irqOut == $past(term))
    else $error("term request wrong");

  pat_hit_a: assert property (
    s_q.patSel |=> s_q.termHit == $past(term))
    else $error("term history wrong");

  ev_pulse_a: assert property (
    s_q.patSel && s_q.evEnable && (|(term & ~s_q.termHit))
      |=> eventOut) else $error("event missed");

  ev_quiet_a: assert property (
    !(s_q.patSel && s_q.evEnable) |=> !eventOut)
    else $error("event without enable");

  open_term_a: assert property (
    s_q.patSel && !s_q.termEnd[0] |=> !irqOut[0])
    else $error("open slice raised request");

  zero_term_a: assert property (
    s_q.patSel && s_q.termEnd[0] && s_q.pmCfg[2:0] == `PIPM_CND_ZERO
      |=> !irqOut[0]) else $error("false slice matched");

  // register port
  rdata_idle_a: assert property (
    !regRd |=> regRdata == '0) else $error("read data not idle");

  read_pins_a: assert property (
    regRd && regAddr == `PIPM_REG_PINS
      |=> regRdata[`PIPM_NCH-1:0] == $past(s_q.pinSync2))
    else $error("pin read wrong");

  read_stat_a: assert property (
    regRd && regAddr == `PIPM_REG_STATUS
      |=> regRdata[`PIPM_NCH-1:0] == $past(irqOut))
    else $error("status read wrong");

  mode_write_a: assert property (
    regWr && regAddr == `PIPM_REG_MODE
      |=> s_q.levelMode == $past(regWdata[`PIPM_NCH-1:0]))
    else $error("mode write lost");

  sel_write_a: assert property (
    regWr && regAddr == `PIPM_REG_PMCTRL
      |=> s_q.patSel == $past(regWdata[`PIPM_PMCTRL_SEL]))
    else $error("pattern select lost");

  ev_write_a: assert property (
    regWr && regAddr == `PIPM_REG_PMCTRL
      |=> s_q.evEnable == $past(regWdata[`PIPM_PMCTRL_EVEN]))
    else $error("event enable lost");

  src_write_a: assert property (
    regWr && regAddr == `PIPM_REG_PMSRC
      |=> s_q.pmSrc == $past(regWdata[$bits(s_q.pmSrc)-1:0]))
    else $error("slice source lost");

  term_write_a: assert property (
    regWr && regAddr == `PIPM_REG_PMTERM
      |=> s_q.termEnd == $past(regWdata[`PIPM_NCH-1:0]))
    else $error("term ends lost");

  // synchroniser
  sync_one_a: assert property (
    ##1 s_q.pinSync1 == $past(pinIn))
    else $error("first sync stage wrong");

  prev_sample_a: assert property (
    ##1 s_q.pinPrev == $past(s_q.pinSync2))
    else $error("previous sample wrong");
endmodule : pipm_engine

// File: pipm_pin_model.sv
// pipm_pin_model.sv: far-side pins, a registered copy of the asked level.
// assumes one clock shared with the block under test.
`timescale 1ns/1ps
module pipm_pin_model
  import pipm_pkg::*;
(
  input  wire logic         clock,
  input  wire pipm_vec_type want,
  output pipm_vec_type      pinIn
);
  // pins move just after an edge, like a synchronous source
  always_ff @(posedge clock) pinIn <= want;
endmodule : pipm_pin_model

// File: pipm_engine_test.sv
// pipm_engine_test.sv: random and corner tests of the pin interrupt block.
// assumes the pin model beside it and a 100 MHz clock.
`timescale 1ns/1ps
`include "pipm_defines.svh"
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin \
  numErrors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module pipm_engine_test;
  import pipm_pkg::*;
  logic         clock = 0;
  logic         rstn = 0;
  pipm_vec_type want = '0;
  pipm_vec_type pinIn, irqOut, p, m;
  logic [5:0]   regAddr = '0;
  logic [31:0]  regWdata = '0, regRdata, rdata;
  logic         regWr = 0, regRd = 0, wakeOut, eventOut;
  int           numErrors = 0, checksDone = 0, evCount = 0, irqHits = 0;
  int           seed = 32'h535d0dd7;
  logic [2:0]   codes [4] = '{`PIPM_CND_HIGH, `PIPM_CND_LOW,
                              `PIPM_CND_ONE, `PIPM_CND_ZERO};
  logic [2:0]   edges [3] = '{`PIPM_CND_RISE, `PIPM_CND_FALL,
                              `PIPM_CND_EDGE};

  pipm_pin_model u_pipm_pin_model (.clock(clock), .want(want),
                                   .pinIn(pinIn));
  pipm_engine u_pipm_engine (.clock(clock), .rstn(rstn), .pinIn(pinIn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irqOut(irqOut), .wakeOut(wakeOut),
    .eventOut(eventOut));

  always #5 clock = ~clock;
  always @(negedge clock) if (eventOut === 1'b1) evCount++;
  always @(negedge clock) if (irqOut[0] === 1'b1) irqHits++;

  task end_of_test;
    if (numErrors == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr

  task rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    d = regRdata;
  endtask : rd

  // seven cycles covers the sync chain plus the registered request
  task setPins(input pipm_vec_type v);
    @(posedge clock);
    want <= v;
    repeat (7) @(posedge clock);
    @(negedge clock);
  endtask : setPins

  function automatic logic expTerm(logic [2:0] c, logic b);
    case (c)
      `PIPM_CND_HIGH: return b;
      `PIPM_CND_LOW:  return ~b;
      `PIPM_CND_ONE:  return 1'b1;
      default:        return 1'b0;
    endcase
  endfunction : expTerm

  // a transition slice matches once per matching edge of its pin
  function automatic int expHits(logic [2:0] c);
    return (c == `PIPM_CND_EDGE) ? 2 : 1;
  endfunction : expHits

  initial begin
    #100000;
    numErrors++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    `CHK("irq reset", 8'h00, irqOut)
    rd(`PIPM_REG_MODE, rdata);
    `CHK("mode reset", 32'h0, rdata)
    wr(6'h3c, 32'hff);
    rd(6'h3c, rdata);
    `CHK("unmapped", 32'h0, rdata)
    for (int i = 0; i < 4; i++) begin
      p = 8'($random(seed)) | 8'h01; // pin 0 always toggles
      wr(`PIPM_REG_MODE, 32'h0);
      wr(`PIPM_REG_ENRISE, 32'hff);
      wr(`PIPM_REG_ENFALL, 32'h0);
      setPins(8'h00);
      wr(`PIPM_REG_RISEFLG, 32'hff);
      wr(`PIPM_REG_FALLFLG, 32'hff);
      setPins(p);
      `CHK("irq rise", p, irqOut)
      `CHK("wake", 1'b1, wakeOut)
      rd(`PIPM_REG_PINS, rdata);
      `CHK("pins", {24'h0, p}, rdata)
      rd(`PIPM_REG_STATUS, rdata);
      `CHK("status", {24'h0, p}, rdata)
      wr(i[0] ? `PIPM_REG_STATUS : `PIPM_REG_RISEFLG, 32'hff);
      setPins(p);
      `CHK("irq clear", 8'h00, irqOut)
      wr(`PIPM_REG_ENRISE, 32'h0);
      wr(`PIPM_REG_ENFALL, 32'hff);
      setPins(8'h00);
      `CHK("irq fall", p, irqOut)
    end
    wr(`PIPM_REG_MODE, 32'hff);
    wr(`PIPM_REG_ENRISE, 32'hff);
    for (int i = 0; i < 4; i++) begin
      p = 8'($random(seed));
      m = 8'($random(seed));
      wr(`PIPM_REG_ENFALL, {24'h0, m});
      setPins(p);
      `CHK("irq level", p ^ m, irqOut)
      `CHK("wake level", |(p ^ m), wakeOut)
    end
    wr(`PIPM_REG_MODE, 32'h0);
    wr(`PIPM_REG_PMSRC, 32'hfac688);
    wr(`PIPM_REG_PMTERM, 32'hff);
    wr(`PIPM_REG_PMCTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      p = 8'($random(seed)) | 8'h02; // term 1 always rises
      wr(`PIPM_REG_PMCFG, {29'h0, codes[i]});
      setPins(8'h00);
      evCount = 0;
      setPins(p);
      `CHK("terms", {p[7:1], expTerm(codes[i], p[0])}, irqOut)
      `CHK("no wake", 1'b0, wakeOut)
      `CHK("events", 1, evCount)
    end
    for (int i = 0; i < 3; i++) begin
      wr(`PIPM_REG_PMCFG, {29'h0, edges[i]});
      setPins(8'h00);
      evCount = 0;
      irqHits = 0;
      setPins(8'h01);
      setPins(8'h00);
      `CHK("edge term", expHits(edges[i]), irqHits)
      `CHK("edge event", expHits(edges[i]), evCount)
    end
    wr(`PIPM_REG_PMCFG, 32'h0);
    wr(`PIPM_REG_PMTERM, 32'h80);
    setPins(8'hff);
    `CHK("and term", 8'h80, irqOut)
    setPins(8'hfe);
    `CHK("and miss", 8'h00, irqOut)
    wr(`PIPM_REG_PMCTRL, 32'h1);
    setPins(8'h00);
    evCount = 0;
    setPins(8'hff);
    `CHK("event off", 0, evCount)
    end_of_test();
  end
endmodule : pipm_engine_test
